// *** hdl/dpfs_pin_route.sv ***
`timescale 1ns/100ps
module dpfs_pin_route
  import dpfs_pkg::*;
(
  input  wire dpfs_func_e func,       // Active function of this pin.
  input  wire logic       spi_master, // Serial engine is master.
  input  wire logic       spi_o,      // Serial engine output for this pin.
  input  wire logic       tmr_o,      // Timer channel output.
  input  wire logic       tmr_oe,     // Timer channel output enable.
  input  wire logic       gpio_dir,   // Port bit direction, 1 is output.
  input  wire logic       gpio_do,    // Port bit output value.
  input  wire logic       pin,        // Synchronised pin level.
  output logic            pad_o,      // Pin output value.
  output logic            pad_oe,     // Pin output enable.
  output logic            dec_in,     // Decoder phase input.
  output logic            tmr_in,     // Timer channel input.
  output logic            spi_in      // Serial engine input.
);

  always_comb begin
    pad_o  = 1'b0;
    pad_oe = 1'b0;
    dec_in = 1'b0;
    tmr_in = 1'b0;
    spi_in = 1'b0;
    case (func)
      DPFS_FN_DEC: begin
        dec_in = pin;
      end
      DPFS_FN_TMR: begin
        pad_o  = tmr_o;
        pad_oe = tmr_oe;
        tmr_in = pin;
      end
      DPFS_FN_SPI: begin
        if (spi_master) begin
          pad_o  = spi_o;
          pad_oe = 1'b1;
        end else begin
          spi_in = pin;
        end
      end
      DPFS_FN_GPIO: begin
        pad_o  = gpio_do;
        pad_oe = gpio_dir;
      end
      default: begin
      end
    endcase
  end

endmodule // dpfs_pin_route

// *** hdl/dpfs_sync.sv ***
`timescale 1ns/100ps
module dpfs_sync #(
  parameter int W = 2
) (
  input  wire logic         core_clk, // System clock.
  input  wire logic         resetn,   // Asynchronous reset, active low.
  input  wire logic [W-1:0] d,        // Level from outside the clock domain.
  output logic      [W-1:0] q         // Synchronised level.
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dpfs_sync_s;

  dpfs_sync_s st_r;
  dpfs_sync_s st_nxt;

  if (W < 1) begin : g_chk
    $error("dpfs_sync width must be at least one");
  end

  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  // Pins idle high under their pull-ups, so reset to ones.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule // dpfs_sync

// *** hdl/dpfs_top.sv ***
`timescale 1ns/100ps
`include "dpfs_consts.svh"
module dpfs_top
  import dpfs_pkg::*;
#(
  parameter int FULL_VARIANT = 1
) (
  input  wire logic       core_clk,                     // System clock, 100 MHz.
  input  wire logic       resetn,                       // Asynchronous reset, active low.
  input  wire logic [3:0] reg_addr,                     // Register address.
  input  wire logic [7:0] reg_wdata,                    // Register write data.
  input  wire logic       reg_wr,                       // Write strobe.
  input  wire logic       reg_rd,                       // Read strobe.
  output logic      [7:0] reg_rdata,                    // Read data, cycle after the strobe.
  input  wire logic [1:0] pad_in,                       // Pin levels, bit 0 phase A.
  output logic      [1:0] pad_out,                      // Pin output values.
  output logic      [1:0] pad_oe,                       // Pin output enables.
  output logic      [1:0] pad_pullup_en,                // Pull-up enables.
  output logic            decoder_phase_a_in,           // Decoder phase A input.
  output logic            decoder_phase_b_in,           // Decoder phase B input.
  input  wire logic [1:0] timer_b_channel_out,          // Timer channels zero and one out.
  input  wire logic [1:0] timer_b_channel_oe,           // Timer channel output enables.
  output logic      [1:0] timer_b_channel_in,           // Timer channel inputs.
  input  wire logic       spi_master_mode,              // Second serial port is master.
  input  wire logic       serial_clock_second_port_out, // Serial clock from engine.
  input  wire logic       master_out_second_port_out,   // Master-out data from engine.
  output logic            serial_clock_second_port_in,  // Serial clock to engine.
  output logic            master_out_second_port_in     // Master-out data to engine.
);

  localparam logic [1:0] CFGD_RST = (FULL_VARIANT != 0) ? `DPFS_CFGD_FULL : `DPFS_CFGD_RED;

  localparam dpfs_top_s ST_RST = '{
    alt:    `DPFS_ALT_RST,
    tsel:   `DPFS_TMR_RST,
    pur:    `DPFS_PUR_RST,
    per:    `DPFS_PER_RST,
    dir:    `DPFS_DIR_RST,
    dout:   `DPFS_DOUT_RST,
    cfgd:   CFGD_RST,
    virgin: 1'b1,
    default: '0
  };

  if (FULL_VARIANT != 0 && FULL_VARIANT != 1) begin : g_chk
    $error("FULL_VARIANT must be 0 or 1");
  end

  dpfs_top_s  st_r;
  dpfs_top_s  st_nxt;
  logic [1:0] pin_s;
  dpfs_func_e func [2];
  logic [1:0] spi_o;
  logic [1:0] r_pad_o;
  logic [1:0] r_pad_oe;
  logic [1:0] r_dec;
  logic [1:0] r_tmr;
  logic [1:0] r_spi;

  dpfs_sync #(
    .W(2)
  ) u_sync (
    .core_clk(core_clk),
    .resetn  (resetn),
    .d       (pad_in),
    .q       (pin_s)
  );

  assign spi_o = {master_out_second_port_out, serial_clock_second_port_out};

  for (genvar i = 0; i < 2; i++) begin : g_pin
    // A pin left unconfigured on the reduced variant serves no function.
    always_comb begin
      if (!st_r.cfgd[i]) begin
        func[i] = DPFS_FN_NONE;
      end else if (!st_r.per[i]) begin
        func[i] = DPFS_FN_GPIO;
      end else if (st_r.alt[i]) begin
        func[i] = DPFS_FN_SPI;
      end else if (st_r.tsel[i]) begin
        func[i] = DPFS_FN_TMR;
      end else begin
        func[i] = DPFS_FN_DEC;
      end
    end

    dpfs_pin_route u_route (
      .func      (func[i]),
      .spi_master(spi_master_mode),
      .spi_o     (spi_o[i]),
      .tmr_o     (timer_b_channel_out[i]),
      .tmr_oe    (timer_b_channel_oe[i]),
      .gpio_dir  (st_r.dir[i]),
      .gpio_do   (st_r.dout[i]),
      .pin       (pin_s[i]),
      .pad_o     (r_pad_o[i]),
      .pad_oe    (r_pad_oe[i]),
      .dec_in    (r_dec[i]),
      .tmr_in    (r_tmr[i]),
      .spi_in    (r_spi[i])
    );
  end

  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = 8'h00;
    if (reg_wr) begin
      st_nxt.virgin = 1'b0;
      if (reg_addr == `DPFS_ADDR_PSEL) begin
        st_nxt.alt  = reg_wdata[`DPFS_PSEL_ALT_LSB +: 2];
        st_nxt.tsel = reg_wdata[`DPFS_PSEL_TMR_LSB +: 2];
        st_nxt.cfgd = 2'h3;
      end else if (reg_addr == `DPFS_ADDR_PUR) begin
        st_nxt.pur = reg_wdata[`DPFS_PIN_LSB +: 2];
      end else if (reg_addr == `DPFS_ADDR_PER) begin
        st_nxt.per  = reg_wdata[`DPFS_PIN_LSB +: 2];
        st_nxt.cfgd = 2'h3;
      end else if (reg_addr == `DPFS_ADDR_DIR) begin
        st_nxt.dir = reg_wdata[`DPFS_PIN_LSB +: 2];
      end else if (reg_addr == `DPFS_ADDR_DOUT) begin
        st_nxt.dout = reg_wdata[`DPFS_PIN_LSB +: 2];
      end
    end
    if (reg_rd) begin
      if (reg_addr == `DPFS_ADDR_PSEL) begin
        st_nxt.rdata = {4'h0, st_r.tsel, st_r.alt};
      end else if (reg_addr == `DPFS_ADDR_PUR) begin
        st_nxt.rdata = {6'h00, st_r.pur};
      end else if (reg_addr == `DPFS_ADDR_PER) begin
        st_nxt.rdata = {6'h00, st_r.per};
      end else if (reg_addr == `DPFS_ADDR_DIR) begin
        st_nxt.rdata = {6'h00, st_r.dir};
      end else if (reg_addr == `DPFS_ADDR_DOUT) begin
        st_nxt.rdata = {6'h00, st_r.dout};
      end else if (reg_addr == `DPFS_ADDR_DIN) begin
        st_nxt.rdata = {6'h00, st_r.din};
      end else if (reg_addr == `DPFS_ADDR_FSA) begin
        st_nxt.rdata = {3'h0, func[0]};
      end else if (reg_addr == `DPFS_ADDR_FSB) begin
        st_nxt.rdata = {3'h0, func[1]};
      end
    end
    // Clock and data see the same one-cycle output stage, so their relative
    // timing set by the serial engine reaches the pins unchanged.
    st_nxt.pad_o   = r_pad_o;
    st_nxt.pad_oe  = r_pad_oe;
    st_nxt.dec_a   = r_dec[0];
    st_nxt.dec_b   = r_dec[1];
    st_nxt.tmr_in  = r_tmr;
    st_nxt.sclk_in = r_spi[0];
    st_nxt.mosi_in = r_spi[1];
    st_nxt.din     = pin_s;
  end

  // Reset leaves both pins undriven with pull-ups on.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata                   = st_r.rdata;
  assign pad_out                     = st_r.pad_o;
  assign pad_oe                      = st_r.pad_oe;
  assign pad_pullup_en               = st_r.pur;
  assign decoder_phase_a_in          = st_r.dec_a;
  assign decoder_phase_b_in          = st_r.dec_b;
  assign timer_b_channel_in          = st_r.tmr_in;
  assign serial_clock_second_port_in = st_r.sclk_in;
  assign master_out_second_port_in   = st_r.mosi_in;

  default clocking cb @(posedge core_clk);
  endclocking

  default disable iff (!resetn);

  sequence s_alt_a_set;
    reg_wr && reg_addr == `DPFS_ADDR_PSEL && reg_wdata[`DPFS_PSEL_ALT_LSB];
  endsequence

  sequence s_alt_b_set;
    reg_wr && reg_addr == `DPFS_ADDR_PSEL && reg_wdata[`DPFS_PSEL_ALT_LSB + 1];
  endsequence

  sequence s_spi_a_master;
    func[0] == DPFS_FN_SPI && spi_master_mode;
  endsequence

  sequence s_spi_b_master;
    func[1] == DPFS_FN_SPI && spi_master_mode;
  endsequence

  sequence s_spi_a_slave;
    func[0] == DPFS_FN_SPI && !spi_master_mode;
  endsequence

  sequence s_spi_b_slave;
    func[1] == DPFS_FN_SPI && !spi_master_mode;
  endsequence

  AST_PUR_A_OFF: assert property (
    (reg_wr && reg_addr == `DPFS_ADDR_PUR && !reg_wdata[0]) ##1 !reg_wr |->
      !pad_pullup_en[0] ##1 !pad_pullup_en[0])
    else $error("phase A pull-up not disabled");

  AST_PUR_B_OFF: assert property (
    reg_wr && reg_addr == `DPFS_ADDR_PUR && !reg_wdata[1] |=> !pad_pullup_en[1])
    else $error("phase B pull-up not disabled");

  AST_ALT_A_ROUTE: assert property (
    s_alt_a_set ##1 st_r.per[0] |-> func[0] == DPFS_FN_SPI)
    else $error("phase A alternate select did not route serial clock");

  AST_ALT_B_ROUTE: assert property (
    s_alt_b_set ##1 st_r.per[1] |-> func[1] == DPFS_FN_SPI)
    else $error("phase B alternate select did not route master-out data");

  AST_SCLK_MASTER: assert property (
    s_spi_a_master |=> pad_oe[0] && pad_out[0] == $past(serial_clock_second_port_out))
    else $error("serial clock not driven in master mode");

  // The synchroniser refills from its reset ones during the first two edges after release,
  // so the pin-following checks start once reset has been high for two edges.
  AST_SCLK_SLAVE: assert property (
    $past(resetn, 2) ##0 s_spi_a_slave |=> !pad_oe[0] && serial_clock_second_port_in == $past(pad_in[0], 3))
    else $error("serial clock not received in slave mode");

  AST_MOSI_MASTER: assert property (
    s_spi_b_master |=> pad_oe[1] && pad_out[1] == $past(master_out_second_port_out))
    else $error("master-out data not driven in master mode");

  AST_MOSI_SLAVE: assert property (
    $past(resetn, 2) ##0 s_spi_b_slave |=> !pad_oe[1] && master_out_second_port_in == $past(pad_in[1], 3))
    else $error("master-out data not sampled in slave mode");

  AST_SPI_SKEW: assert property (
    (s_spi_a_master and s_spi_b_master) |=>
      {pad_out[1], pad_out[0]} == {$past(master_out_second_port_out), $past(serial_clock_second_port_out)})
    else $error("clock and data reach the pins with unequal delay");

  AST_DEFAULT_A: assert property (
    FULL_VARIANT != 0 && st_r.virgin |-> func[0] == DPFS_FN_DEC)
    else $error("phase A pin not on decoder after reset");

  AST_DEC_A: assert property (
    func[0] == DPFS_FN_DEC && $past(resetn, 2) |=> !pad_oe[0] && decoder_phase_a_in == $past(pad_in[0], 3))
    else $error("decoder phase A does not follow the pin");

  AST_DEFAULT_B: assert property (
    FULL_VARIANT != 0 && st_r.virgin |-> func[1] == DPFS_FN_DEC)
    else $error("phase B pin not on decoder after reset");

  AST_DEC_B: assert property (
    func[1] == DPFS_FN_DEC && $past(resetn, 2) |=> !pad_oe[1] && decoder_phase_b_in == $past(pad_in[1], 3))
    else $error("decoder phase B does not follow the pin");

  AST_NONE_DEFAULT: assert property (
    FULL_VARIANT == 0 && st_r.virgin |-> func[0] == DPFS_FN_NONE && func[1] == DPFS_FN_NONE)
    else $error("reduced variant pin selected a function before setup");

  AST_RESET_INPUT: assert property (
    st_r.virgin |-> pad_oe == 2'h0 && pad_pullup_en == 2'h3)
    else $error("pins not inputs with pull-ups after reset");

  AST_PUR_A_ON: assert property (
    reg_wr && reg_addr == `DPFS_ADDR_PUR && reg_wdata[0] |=> pad_pullup_en[0])
    else $error("phase A pull-up not enabled");

  AST_PUR_B_ON: assert property (
    reg_wr && reg_addr == `DPFS_ADDR_PUR && reg_wdata[1] |=> pad_pullup_en[1])
    else $error("phase B pull-up not enabled");

  AST_ALT_A_CLEAR: assert property (
    reg_wr && reg_addr == `DPFS_ADDR_PSEL && !reg_wdata[`DPFS_PSEL_ALT_LSB] |=> func[0] != DPFS_FN_SPI)
    else $error("phase A left on the serial clock after deselect");

  AST_ALT_B_CLEAR: assert property (
    reg_wr && reg_addr == `DPFS_ADDR_PSEL && !reg_wdata[`DPFS_PSEL_ALT_LSB + 1] |=> func[1] != DPFS_FN_SPI)
    else $error("phase B left on the master-out data after deselect");

  AST_SCLK_IDLE: assert property (
    func[0] != DPFS_FN_SPI |=> !serial_clock_second_port_in)
    else $error("serial clock input active while phase A serves another function");

  AST_MOSI_IDLE: assert property (
    func[1] != DPFS_FN_SPI |=> !master_out_second_port_in)
    else $error("master-out data input active while phase B serves another function");

  AST_SCLK_MASTER_IN: assert property (
    s_spi_a_master |=> !serial_clock_second_port_in)
    else $error("serial clock fed back to the engine in master mode");

  AST_MOSI_MASTER_IN: assert property (
    s_spi_b_master |=> !master_out_second_port_in)
    else $error("master-out data fed back to the engine in master mode");

  AST_DEC_A_IDLE: assert property (
    func[0] != DPFS_FN_DEC |=> !decoder_phase_a_in)
    else $error("decoder phase A active while the pin serves another function");

  AST_DEC_B_IDLE: assert property (
    func[1] != DPFS_FN_DEC |=> !decoder_phase_b_in)
    else $error("decoder phase B active while the pin serves another function");

  // Read data must be zero outside the answer cycle, so a late sample never sees stale data.
  AST_RDATA_IDLE: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside the answer cycle");

  AST_FUNC_A_READ: assert property (
    reg_rd && reg_addr == `DPFS_ADDR_FSA |=> reg_rdata == {3'h0, $past(func[0])})
    else $error("phase A function code read back wrongly");

  for (genvar k = 0; k < 2; k++) begin : g_ast
    AST_GPIO_DRIVE: assert property (
      func[k] == DPFS_FN_GPIO |=> pad_oe[k] == $past(st_r.dir[k]) && pad_out[k] == $past(st_r.dout[k]))
      else $error("port bit direction or value not applied");

    AST_TMR_PATH: assert property (
      func[k] == DPFS_FN_TMR && $past(resetn, 2) |=> pad_oe[k] == $past(timer_b_channel_oe[k]) &&
        pad_out[k] == $past(timer_b_channel_out[k]) && timer_b_channel_in[k] == $past(pad_in[k], 3))
      else $error("timer channel path broken");

    AST_NONE_QUIET: assert property (
      func[k] == DPFS_FN_NONE |=> !pad_oe[k] && !pad_out[k] && !timer_b_channel_in[k])
      else $error("unconfigured pin is not quiet");

    AST_TMR_IDLE: assert property (
      func[k] != DPFS_FN_TMR |=> !timer_b_channel_in[k])
      else $error("timer channel input active while the pin serves another function");
  end

endmodule // dpfs_top

// *** pkg/dpfs_consts.svh ***
`ifndef DPFS_CONSTS_SVH
`define DPFS_CONSTS_SVH

// Register offsets.
`define DPFS_ADDR_PSEL 4'h0
`define DPFS_ADDR_PUR  4'h1
`define DPFS_ADDR_PER  4'h2
`define DPFS_ADDR_DIR  4'h3
`define DPFS_ADDR_DOUT 4'h4
`define DPFS_ADDR_DIN  4'h5
`define DPFS_ADDR_FSA  4'h6
`define DPFS_ADDR_FSB  4'h7

// Field positions; per-pin fields start at bit 0 with phase A.
`define DPFS_PSEL_ALT_LSB 0
`define DPFS_PSEL_TMR_LSB 2
`define DPFS_PIN_LSB      0

// Reset values.
`define DPFS_ALT_RST  2'h0
`define DPFS_TMR_RST  2'h0
`define DPFS_PUR_RST  2'h3
`define DPFS_PER_RST  2'h3
`define DPFS_DIR_RST  2'h0
`define DPFS_DOUT_RST 2'h0
`define DPFS_CFGD_FULL 2'h3
`define DPFS_CFGD_RED  2'h0

`endif

// *** pkg/dpfs_pkg.sv ***
package dpfs_pkg;

  typedef enum logic [4:0] {
    DPFS_FN_NONE = 5'h01,
    DPFS_FN_DEC  = 5'h02,
    DPFS_FN_TMR  = 5'h04,
    DPFS_FN_SPI  = 5'h08,
    DPFS_FN_GPIO = 5'h10
  } dpfs_func_e;

  typedef struct packed {
    logic [1:0] alt;
    logic [1:0] tsel;
    logic [1:0] pur;
    logic [1:0] per;
    logic [1:0] dir;
    logic [1:0] dout;
    logic [1:0] cfgd;
    logic       virgin;
    logic [7:0] rdata;
    logic [1:0] pad_o;
    logic [1:0] pad_oe;
    logic       dec_a;
    logic       dec_b;
    logic [1:0] tmr_in;
    logic       sclk_in;
    logic       mosi_in;
    logic [1:0] din;
  } dpfs_top_s;

endpackage

// *** sim/dpfs_far_side.sv ***
`timescale 1ns/100ps
module dpfs_far_side (
  input  wire logic [1:0] pad_out,       // Device drive values.
  input  wire logic [1:0] pad_oe,        // Device output enables.
  input  wire logic [1:0] pad_pullup_en, // Device pull-up enables.
  input  wire logic [1:0] ext_drv,       // Level the outside party drives.
  input  wire logic [1:0] ext_en,        // Outside party drives the pin.
  output logic      [1:0] pad_in         // Resolved pin levels.
);
  logic [1:0] last_r = 2'h0;

  // A pin nobody drives and nothing pulls shows the inverse of the last level driven onto it, so a stale value never passes.
  always @* begin
    for (int i = 0; i < 2; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_drv[i];
      end else if (pad_pullup_en[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = ~last_r[i];
      end
      if (pad_oe[i] | ext_en[i]) begin
        last_r[i] = pad_in[i];
      end
    end
  end
endmodule // dpfs_far_side

// *** sim/dpfs_top_tb_top.sv ***
`timescale 1ns/100ps
module dpfs_top_tb_top;
  logic       core_clk  = 1'b0;
  logic       resetn    = 1'b0;
  logic [3:0] reg_addr  = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [1:0] tmr_out   = 2'h0;
  logic [1:0] tmr_oe    = 2'h0;
  logic [1:0] ext_drv   = 2'h2;
  logic [1:0] ext_en    = 2'h3;
  logic       spi_m     = 1'b0;
  logic       sclk_o    = 1'b0;
  logic       mosi_o    = 1'b0;
  logic [7:0] rdata, red_rdata, rd_full, rd_red;
  logic [1:0] pad_in, pad_out, pad_oe, pull, tmr_in;
  logic       dec_a, dec_b, sclk_i, mosi_i;
  int         n_errors    = 0;
  int         check_count = 0;

  always #5 core_clk = ~core_clk;

  dpfs_top #(.FULL_VARIANT(1)) dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pull), .decoder_phase_a_in(dec_a),
    .decoder_phase_b_in(dec_b), .timer_b_channel_out(tmr_out), .timer_b_channel_oe(tmr_oe),
    .timer_b_channel_in(tmr_in), .spi_master_mode(spi_m), .serial_clock_second_port_out(sclk_o),
    .master_out_second_port_out(mosi_o), .serial_clock_second_port_in(sclk_i),
    .master_out_second_port_in(mosi_i));

  // The reduced variant only answers register reads; its pins are not judged here.
  dpfs_top #(.FULL_VARIANT(0)) dut_red (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(red_rdata), .pad_in(pad_in),
    .pad_out(), .pad_oe(), .pad_pullup_en(), .decoder_phase_a_in(), .decoder_phase_b_in(),
    .timer_b_channel_out(tmr_out), .timer_b_channel_oe(tmr_oe), .timer_b_channel_in(),
    .spi_master_mode(spi_m), .serial_clock_second_port_out(sclk_o), .master_out_second_port_out(mosi_o),
    .serial_clock_second_port_in(), .master_out_second_port_in());

  dpfs_far_side far (.pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pull), .ext_drv(ext_drv),
    .ext_en(ext_en), .pad_in(pad_in));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd_full = rdata;
    rd_red  = red_rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    cyc(19);
    chk("pullup in reset", 8'h03, {6'h00, pull});
    chk("oe in reset", 8'h00, {6'h00, pad_oe});
    @(posedge core_clk);
    resetn <= 1'b1;
    rd(4'h6);
    chk("func a", 8'h02, rd_full);
    chk("red func a", 8'h01, rd_red);
    rd(4'h7);
    chk("func b", 8'h02, rd_full);
    chk("red func b", 8'h01, rd_red);
    for (int p = 1; p < 3; p++) begin
      @(posedge core_clk);
      ext_drv <= p[1:0];
      cyc(5);
      chk("decoder ins", {6'h00, p[1:0]}, {6'h00, dec_b, dec_a});
    end
    @(posedge core_clk);
    ext_en <= 2'h0;
    wr(4'h1, 8'h02);
    cyc(2);
    chk("pullup a off", 8'h02, {6'h00, pull});
    wr(4'h1, 8'h01);
    cyc(2);
    chk("pullup b off", 8'h01, {6'h00, pull});
    wr(4'h1, 8'h03);
    rd(4'h1);
    chk("pullup readback", 8'h03, rd_full);
    // Both variants must be configured before the serial function can appear.
    wr(4'h0, 8'h03);
    rd(4'h6);
    chk("func a spi", 8'h08, rd_full);
    chk("red func a spi", 8'h08, rd_red);
    rd(4'h7);
    chk("func b spi", 8'h08, rd_full);
    chk("red func b spi", 8'h08, rd_red);
    @(posedge core_clk);
    spi_m <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      @(posedge core_clk);
      {mosi_o, sclk_o} <= p[1:0];
      cyc(3);
      chk("spi master oe", 8'h03, {6'h00, pad_oe});
      chk("spi master out", {6'h00, p[1:0]}, {6'h00, pad_out});
      chk("spi master quiet in", 8'h00, {6'h00, mosi_i, sclk_i});
    end
    @(posedge core_clk);
    spi_m  <= 1'b0;
    ext_en <= 2'h3;
    for (int p = 0; p < 4; p++) begin
      @(posedge core_clk);
      ext_drv <= p[1:0];
      cyc(5);
      chk("spi slave oe", 8'h00, {6'h00, pad_oe});
      chk("spi slave in", {6'h00, p[1:0]}, {6'h00, mosi_i, sclk_i});
    end
    wr(4'h0, 8'h0C);
    rd(4'h0);
    chk("select readback", 8'h0C, rd_full);
    rd(4'h6);
    chk("func a timer", 8'h04, rd_full);
    @(posedge core_clk);
    tmr_oe <= 2'h3;
    for (int p = 0; p < 4; p++) begin
      @(posedge core_clk);
      tmr_out <= p[1:0];
      cyc(3);
      chk("timer out", {6'h00, p[1:0]}, {6'h00, pad_out});
      chk("timer oe", 8'h03, {6'h00, pad_oe});
    end
    @(posedge core_clk);
    tmr_oe  <= 2'h0;
    ext_drv <= 2'h1;
    cyc(5);
    chk("timer in", 8'h01, {6'h00, tmr_in});
    chk("decoder idle", 8'h00, {6'h00, dec_b, dec_a});
    wr(4'h2, 8'h00);
    rd(4'h2);
    chk("enable readback", 8'h00, rd_full);
    rd(4'h7);
    chk("func b gpio", 8'h10, rd_full);
    @(posedge core_clk);
    ext_en  <= 2'h2;
    ext_drv <= 2'h2;
    wr(4'h3, 8'h01);
    wr(4'h4, 8'h03);
    cyc(3);
    chk("gpio oe a", 8'h01, {6'h00, pad_oe});
    chk("gpio out a", 8'h01, {7'h00, pad_out[0]});
    cyc(3);
    rd(4'h5);
    chk("gpio din", 8'h03, rd_full);
    rd(4'h3);
    chk("direction readback", 8'h01, rd_full);
    rd(4'h4);
    chk("data out readback", 8'h03, rd_full);
    @(posedge core_clk);
    ext_en  <= 2'h1;
    ext_drv <= 2'h0;
    wr(4'h3, 8'h02);
    cyc(6);
    chk("gpio oe b", 8'h02, {6'h00, pad_oe});
    rd(4'h5);
    chk("gpio din b", 8'h02, rd_full);
    wr(4'h6, 8'hFF);
    rd(4'h6);
    chk("func a read only", 8'h10, rd_full);
    rd(4'hF);
    chk("unmapped read", 8'h00, rd_full);
    report_and_stop();
  end

  // The tests need under two thousand cycles; twenty thousand means a hang.
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
endmodule // dpfs_top_tb_top
